// file: atpl_pkg.sv
// Constants, register map and types for the test pattern and latency block
package atpl_pkg;
  // Widths and ring depth
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SMP_W = 14;
  localparam int unsigned RING_AW = 7;
  localparam int unsigned RING_DEPTH = 128;
  localparam int unsigned USER_REGS = 8;
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_APP_MODE = 12'h0200;
  localparam logic [ADDR_W-1:0] OFS_DECIM = 12'h0201;
  localparam logic [ADDR_W-1:0] OFS_DDC0_CTRL = 12'h0327;
  localparam logic [ADDR_W-1:0] OFS_DDC1_CTRL = 12'h0347;
  localparam logic [ADDR_W-1:0] OFS_TEST_SEL = 12'h0550;
  localparam logic [ADDR_W-1:0] OFS_USER_FIRST = 12'h0551;
  localparam logic [ADDR_W-1:0] OFS_USER_LAST = 12'h0558;
  localparam logic [ADDR_W-1:0] OFS_LINK_CFG = 12'h0570;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h05F0;
  localparam logic [ADDR_W-1:0] OFS_LATENCY = 12'h05F1;
  // Field positions
  localparam int unsigned BIT_APP_DDC = 0;
  localparam int unsigned BIT_DDC_TEST_I = 0;
  localparam int unsigned BIT_DDC_TEST_Q = 2;
  localparam int unsigned BIT_PN_LONG_RST = 4;
  localparam int unsigned BIT_PN_SHORT_RST = 5;
  localparam int unsigned BIT_USER_SINGLE = 7;
  // Reset values
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [SMP_W-1:0] SMP_RESET = 14'h0000;
  // Test pattern select codes
  typedef enum logic [3:0] {
    TP_OFF = 4'b0000,
    TP_MID = 4'b0001,
    TP_POS = 4'b0010,
    TP_NEG = 4'b0011,
    TP_CHECK = 4'b0100,
    TP_PN_LONG = 4'b0101,
    TP_PN_SHORT = 4'b0110,
    TP_TOGGLE = 4'b0111,
    TP_USER = 4'b1000,
    TP_RAMP = 4'b1111
  } atpl_mode_t;
  // Pattern words
  localparam logic [SMP_W-1:0] PAT_MID = 14'h0000;
  localparam logic [SMP_W-1:0] PAT_POS = 14'h1FFF;
  localparam logic [SMP_W-1:0] PAT_NEG = 14'h2000;
  localparam logic [SMP_W-1:0] PAT_CHK_A = 14'h1555;
  localparam logic [SMP_W-1:0] PAT_CHK_B = 14'h2AAA;
  localparam logic [SMP_W-1:0] PAT_ZERO = 14'h0000;
  localparam logic [SMP_W-1:0] PAT_ONES = 14'h3FFF;
  localparam logic [SMP_W-1:0] RAMP_STEP = 14'h0001;
  localparam logic [1:0] USER_LAST_IDX = 2'h3;
  // Pseudo-random generators
  localparam int unsigned PN_LONG_LEN = 23;
  localparam int unsigned PN_SHORT_LEN = 9;
  localparam int unsigned PN_LONG_TAP = 5;
  localparam int unsigned PN_SHORT_TAP = 4;
  localparam logic [PN_LONG_LEN-1:0] SEED_LONG = 23'h00_3AFF;
  localparam logic [PN_LONG_LEN-1:0] SEED_SHORT = 23'h00_0092;
  localparam logic [SMP_W-1:0] PN_FIRST_LONG = 14'h3FD7;
  localparam logic [SMP_W-1:0] PN_FIRST_SHORT = 14'h125B;
  // Latencies in encode clocks
  localparam int unsigned LAT_CONV = 26;
  localparam int unsigned LAT_FULL_BW = 29;
  localparam int unsigned LAT_HB1_CPLX = 78;
  localparam int unsigned LNK_LAT_1L2M = 7;
  localparam int unsigned LNK_LAT_1L1M = 13;
  localparam int unsigned LNK_LAT_2L1M = 28;
  localparam int unsigned LNK_LAT_4L1M = 53;
  localparam int unsigned LNK_LAT_4L2M_DEC = 30;
  localparam int unsigned LNK_LAT_2L8M = 4;
  localparam int unsigned LNK_LAT_1L8M = 2;
  // Link quick configuration codes
  localparam logic [7:0] QC_1L1M = 8'h01;
  localparam logic [7:0] QC_2L1M_F1 = 8'h40;
  localparam logic [7:0] QC_2L1M_F2 = 8'h41;
  localparam logic [7:0] QC_4L1M_F1 = 8'h80;
  localparam logic [7:0] QC_4L1M_F2 = 8'h81;
  localparam logic [7:0] QC_1L2M = 8'h0A;
  localparam logic [7:0] QC_2L2M = 8'h49;
  localparam logic [7:0] QC_4L2M_F1 = 8'h88;
  localparam logic [7:0] QC_4L2M_F2 = 8'h89;
  localparam logic [7:0] QC_2L4M = 8'h52;
  localparam logic [7:0] QC_4L4M = 8'h91;
  localparam logic [7:0] QC_1L8M = 8'h1C;
  localparam logic [7:0] QC_2L8M = 8'h5B;
  localparam logic [7:0] QC_4L8M = 8'h9A;
  // Decimation codes and settle time
  localparam logic [2:0] DEC_BY_1 = 3'h0;
  localparam logic [2:0] DEC_BY_2 = 3'h1;
  localparam logic [2:0] DEC_MAX_CODE = 3'h4;
  localparam logic [7:0] CFG_SETTLE = 8'hFF;
endpackage

// file: atpl_top.sv
// Test pattern generator and latency pipeline of a dual converter back end
//
// What this block does
// - Converter core output lags the sampled input by exactly 26 encode clocks.
// - Converter plus processing delay is 29 full bandwidth, 78 first halfband.
// - Total delay is processing delay plus the link delay of the chosen setup.
// - Full bandwidth link delay follows lanes and converters, 2 up to 53 clocks.
// - Four lanes, two converters with decimation by 2 give 30 instead of 28.
// - Four and eight converter decimating setups keep delay for any ratio.
// - Any enabled pattern replaces converter samples ahead of output formatting.
// - Either reset bit of the select register restarts both noise generators.
// - Patterns ignore the analog samples but still need the running encode clock.
// - In down-converter test, in-phase carries channel A, quadrature channel B.
// - Codes 0000 off, 0001 midscale, 0010 positive, 0011 negative full scale.
// - Code 0100 alternates 0x1555 and 0x2AAA on successive samples.
// - Code 0101 long noise x^23+x^18+1, seed 0x3AFF, starts 0x3FD7, 0x0002.
// - Code 0110 short noise x^9+x^5+1, seed 0x0092, starts 0x125B, 0x3C9A.
// - Code 0111 alternates 0x0000 and 0x3FFF on successive samples.
// - Code 1111 ramps by one per sample modulo 2^14; 0000 disables all.
// - Code 1000 repeat: user words 1 to 4, bits 15 to 2, cycling forever.
// - Code 1000 single: the four user words once, then zero words.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module atpl_top
  import atpl_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  // Converted samples, one per encode clock
  input wire logic [SMP_W-1:0] sample_a_in,
  input wire logic [SMP_W-1:0] sample_b_in,
  // Converter core output
  output logic [SMP_W-1:0] conv_a_out,
  output logic [SMP_W-1:0] conv_b_out,
  // Output of converter plus processing
  output logic proc_valid_out,
  output logic [SMP_W-1:0] proc_a_out,
  output logic [SMP_W-1:0] proc_b_out,
  // Output after the link block delay
  output logic link_valid_out,
  output logic [SMP_W-1:0] link_a_out,
  output logic [SMP_W-1:0] link_b_out
);

  logic [DATA_W-1:0] app_mode_reg, decim_reg, ddc0_ctrl_reg, ddc1_ctrl_reg;
  logic [DATA_W-1:0] test_sel_reg, link_cfg_reg;
  logic [DATA_W-1:0] user_reg [USER_REGS];
  logic [DATA_W-1:0] read_next;
  logic [7:0] cfg_age_reg;
  logic [3:0] dec_cnt_reg, dec_limit;
  logic sample_strobe;
  atpl_mode_t test_mode, mode_q_reg;
  logic test_active, gen_restart, pn_restart, pn_rst, ddc_mode, test_a_en, test_b_en;
  logic phase_reg, phase_cur;
  logic [SMP_W-1:0] ramp_reg, ramp_cur, user_word, pn_word, pattern_word;
  logic [SMP_W-1:0] lane_a_word, lane_b_word;
  logic [1:0] user_idx_reg, user_idx_cur;
  logic [2*DATA_W-1:0] user_pair;
  logic user_done_reg, user_done_cur;
  logic [PN_LONG_LEN-1:0] pn_reg, pn_cur;
  logic [PN_LONG_LEN+SMP_W-1:0] pn_next;
  logic [2*SMP_W-1:0] conv_ring [RING_DEPTH];
  logic [2*SMP_W:0] proc_ring [RING_DEPTH];
  logic [RING_AW-1:0] wr_ptr_reg, conv_rd, proc_rd, link_rd, proc_k, link_k;
  logic [7:0] proc_lat, link_lat;

  // True when an address falls on one of the user pattern bytes
  function automatic logic is_user(input logic [ADDR_W-1:0] addr);
    return (addr >= OFS_USER_FIRST) && (addr <= OFS_USER_LAST);
  endfunction

  // Byte index of a user pattern register
  function automatic logic [2:0] user_sel(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] d;
    d = addr - OFS_USER_FIRST;
    return d[2:0];
  endfunction

  // Link block delay for a quick configuration and decimation code
  function automatic int unsigned link_latency(input logic [7:0] cfg, input logic [2:0] dec);
    case (cfg)
      QC_1L1M, QC_2L2M, QC_4L4M: return LNK_LAT_1L1M;
      QC_2L1M_F1, QC_2L1M_F2: return LNK_LAT_2L1M;
      QC_4L1M_F1, QC_4L1M_F2: return LNK_LAT_4L1M;
      QC_1L2M, QC_2L4M, QC_4L8M: return LNK_LAT_1L2M;
      QC_4L2M_F1, QC_4L2M_F2: return (dec == DEC_BY_1) ? LNK_LAT_2L1M : LNK_LAT_4L2M_DEC;
      QC_2L8M: return LNK_LAT_2L8M;
      QC_1L8M: return LNK_LAT_1L8M;
      default: return LNK_LAT_1L1M;
    endcase
  endfunction

  // Advances a noise generator by one 14-bit word, first bit lands in the MSB
  function automatic logic [PN_LONG_LEN+SMP_W-1:0] pn_adv(
    input logic [PN_LONG_LEN-1:0] s_in,
    input logic is_long
  );
    logic [PN_LONG_LEN-1:0] s;
    logic [SMP_W-1:0] w;
    logic fb;
    s = s_in;
    w = PAT_ZERO;
    fb = 1'b0;
    for (int i = 0; i < SMP_W; i++)
    begin
      w = {w[SMP_W-2:0], s[0]};
      if (is_long)
      begin
        fb = s[0] ^ s[PN_LONG_TAP];
        s = {fb, s[PN_LONG_LEN-1:1]};
      end
      else
      begin
        fb = s[0] ^ s[PN_SHORT_TAP];
        s = {{(PN_LONG_LEN-PN_SHORT_LEN){1'b0}}, fb, s[PN_SHORT_LEN-1:1]};
      end
    end
    return {s, w};
  endfunction

  // Control register writes
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      app_mode_reg <= REG_RESET;
      decim_reg <= REG_RESET;
      ddc0_ctrl_reg <= REG_RESET;
      ddc1_ctrl_reg <= REG_RESET;
      test_sel_reg <= REG_RESET;
      link_cfg_reg <= REG_RESET;
    end
    else if (reg_write_in)
    begin
      case (reg_addr_in)
        OFS_APP_MODE: app_mode_reg <= reg_wdata_in;
        OFS_DECIM: decim_reg <= reg_wdata_in;
        OFS_DDC0_CTRL: ddc0_ctrl_reg <= reg_wdata_in;
        OFS_DDC1_CTRL: ddc1_ctrl_reg <= reg_wdata_in;
        OFS_TEST_SEL: test_sel_reg <= reg_wdata_in;
        OFS_LINK_CFG: link_cfg_reg <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // User pattern bytes
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      for (int i = 0; i < USER_REGS; i++)
      begin
        user_reg[i] <= REG_RESET;
      end
    end
    else if (reg_write_in && is_user(reg_addr_in))
    begin
      user_reg[user_sel(reg_addr_in)] <= reg_wdata_in;
    end
  end

  // Read selection, unmapped addresses read zero
  always_comb
  begin
    read_next = REG_RESET;
    if (is_user(reg_addr_in))
    begin
      read_next = user_reg[user_sel(reg_addr_in)];
    end
    else
    begin
      case (reg_addr_in)
        OFS_APP_MODE: read_next = app_mode_reg;
        OFS_DECIM: read_next = decim_reg;
        OFS_DDC0_CTRL: read_next = ddc0_ctrl_reg;
        OFS_DDC1_CTRL: read_next = ddc1_ctrl_reg;
        OFS_TEST_SEL: read_next = test_sel_reg;
        OFS_LINK_CFG: read_next = link_cfg_reg;
        OFS_STATUS: read_next = {4'h0, test_active, user_done_reg, user_idx_reg};
        OFS_LATENCY: read_next = proc_lat + link_lat;
        default: read_next = REG_RESET;
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
      reg_rdata_out <= REG_RESET;
    else if (reg_read_in)
      reg_rdata_out <= read_next;
    else
      reg_rdata_out <= REG_RESET;
  end

  // Cycles since reset or the last register write, saturating
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
      cfg_age_reg <= 8'h00;
    else if (reg_write_in)
      cfg_age_reg <= 8'h00;
    else if (cfg_age_reg != CFG_SETTLE)
      cfg_age_reg <= cfg_age_reg + 8'h01;
  end

  // Output sample strobe at the encode rate over the decimation ratio
  assign dec_limit = (decim_reg[2:0] > DEC_MAX_CODE) ? 4'hF :
                     4'((5'h01 << decim_reg[2:0]) - 5'h01);
  assign sample_strobe = (dec_cnt_reg == 4'h0);
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
      dec_cnt_reg <= 4'h0;
    else if (dec_cnt_reg >= dec_limit)
      dec_cnt_reg <= 4'h0;
    else
      dec_cnt_reg <= dec_cnt_reg + 4'h1;
  end

  // Mode decode and lane enables
  assign test_mode = atpl_mode_t'(test_sel_reg[3:0]);
  assign test_active = (test_mode != TP_OFF);
  assign ddc_mode = app_mode_reg[BIT_APP_DDC];
  assign pn_rst = test_sel_reg[BIT_PN_LONG_RST] | test_sel_reg[BIT_PN_SHORT_RST];
  assign test_a_en = test_active && (!ddc_mode || ddc0_ctrl_reg[BIT_DDC_TEST_I] ||
                     ddc1_ctrl_reg[BIT_DDC_TEST_I]);
  assign test_b_en = test_active && (!ddc_mode || ddc0_ctrl_reg[BIT_DDC_TEST_Q] ||
                     ddc1_ctrl_reg[BIT_DDC_TEST_Q]);

  // Generators restart from their first value when a pattern is chosen
  assign gen_restart = !test_active || (test_mode != mode_q_reg);
  assign pn_restart = gen_restart || pn_rst;
  assign phase_cur = gen_restart ? 1'b0 : phase_reg;
  assign ramp_cur = gen_restart ? PAT_ZERO : ramp_reg;
  assign user_idx_cur = gen_restart ? 2'h0 : user_idx_reg;
  assign user_done_cur = gen_restart ? 1'b0 : user_done_reg;
  assign pn_cur = !pn_restart ? pn_reg : (test_mode == TP_PN_LONG) ? SEED_LONG : SEED_SHORT;
  assign pn_next = pn_adv(pn_cur, test_mode == TP_PN_LONG);
  assign pn_word = pn_next[SMP_W-1:0];
  assign user_pair = {user_reg[{user_idx_cur, 1'b0}], user_reg[{user_idx_cur, 1'b1}]};
  assign user_word = user_pair[2*DATA_W-1:2*DATA_W-SMP_W];

  // Mode memory for restart detection
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
      mode_q_reg <= TP_OFF;
    else
      mode_q_reg <= test_mode;
  end

  // Alternation phase for checkerboard and word toggle
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
      phase_reg <= 1'b0;
    else
      phase_reg <= sample_strobe ? !phase_cur : phase_cur;
  end

  // Ramp counter, wraps at 14 bits
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
      ramp_reg <= PAT_ZERO;
    else
      ramp_reg <= sample_strobe ? ramp_cur + RAMP_STEP : ramp_cur;
  end

  // User word sequencing, repeat or single
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      user_idx_reg <= 2'h0;
      user_done_reg <= 1'b0;
    end
    else
    begin
      user_idx_reg <= user_idx_cur;
      user_done_reg <= user_done_cur;
      if (sample_strobe && !user_done_cur)
      begin
        user_idx_reg <= user_idx_cur + 2'h1;
        if (user_idx_cur == USER_LAST_IDX)
          user_done_reg <= test_sel_reg[BIT_USER_SINGLE];
      end
    end
  end

  // Noise generator state
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
      pn_reg <= SEED_SHORT;
    else
      pn_reg <= sample_strobe ? pn_next[PN_LONG_LEN+SMP_W-1:SMP_W] : pn_cur;
  end

  // Pattern word for the selected mode
  always_comb
  begin
    case (test_mode)
      TP_MID: pattern_word = PAT_MID;
      TP_POS: pattern_word = PAT_POS;
      TP_NEG: pattern_word = PAT_NEG;
      TP_CHECK: pattern_word = phase_cur ? PAT_CHK_B : PAT_CHK_A;
      TP_PN_LONG: pattern_word = pn_word;
      TP_PN_SHORT: pattern_word = pn_word;
      TP_TOGGLE: pattern_word = phase_cur ? PAT_ONES : PAT_ZERO;
      TP_USER: pattern_word = user_done_cur ? PAT_ZERO : user_word;
      TP_RAMP: pattern_word = ramp_cur;
      default: pattern_word = PAT_ZERO;
    endcase
  end

  // Pattern replaces converter words; analog samples play no part in it
  assign lane_a_word = test_a_en ? pattern_word : conv_a_out;
  assign lane_b_word = test_b_en ? pattern_word : conv_b_out;

  // Delay taps for the selected application mode and link setup
  assign proc_lat = 8'(ddc_mode ? LAT_HB1_CPLX : LAT_FULL_BW);
  assign link_lat = 8'(link_latency(link_cfg_reg, decim_reg[2:0]));
  assign proc_k = RING_AW'(proc_lat - 8'(LAT_CONV + 1));
  assign link_k = proc_k + RING_AW'(link_lat);
  assign conv_rd = wr_ptr_reg - RING_AW'(LAT_CONV - 1);
  assign proc_rd = wr_ptr_reg - proc_k;
  assign link_rd = wr_ptr_reg - link_k;

  // Delay rings, no reset needed for data storage
  always_ff @(posedge clk_sys_in)
  begin
    conv_ring[wr_ptr_reg] <= {sample_a_in, sample_b_in};
    proc_ring[wr_ptr_reg] <= {sample_strobe, lane_a_word, lane_b_word};
  end

  // Ring pointer and registered tap outputs
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      wr_ptr_reg <= '0;
      {conv_a_out, conv_b_out} <= {SMP_RESET, SMP_RESET};
      {proc_valid_out, proc_a_out, proc_b_out} <= {1'b0, SMP_RESET, SMP_RESET};
      {link_valid_out, link_a_out, link_b_out} <= {1'b0, SMP_RESET, SMP_RESET};
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_reg + RING_AW'(1);
      {conv_a_out, conv_b_out} <= conv_ring[conv_rd];
      {proc_valid_out, proc_a_out, proc_b_out} <= proc_ring[proc_rd];
      {link_valid_out, link_a_out, link_b_out} <= proc_ring[link_rd];
    end
  end

  property p_conv_delay;
    @(posedge clk_sys_in) disable iff (reset_in)
    (cfg_age_reg == CFG_SETTLE) |-> (conv_a_out == $past(sample_a_in, LAT_CONV));
  endproperty
  a_conv_delay: assert property (p_conv_delay)
    else $error("Converter delay is not 26 clocks");

  property p_full_bw_delay;
    @(posedge clk_sys_in) disable iff (reset_in)
    (cfg_age_reg == CFG_SETTLE && !ddc_mode) |->
      (proc_a_out == $past(lane_a_word, LAT_FULL_BW - LAT_CONV));
  endproperty
  a_full_bw_delay: assert property (p_full_bw_delay)
    else $error("Full bandwidth delay is not 29 clocks");

  property p_hb1_delay;
    @(posedge clk_sys_in) disable iff (reset_in)
    (cfg_age_reg == CFG_SETTLE && ddc_mode) |->
      (proc_b_out == $past(lane_b_word, LAT_HB1_CPLX - LAT_CONV));
  endproperty
  a_hb1_delay: assert property (p_hb1_delay)
    else $error("First halfband delay is not 78 clocks");

  property p_link_1l2m;
    @(posedge clk_sys_in) disable iff (reset_in)
    (cfg_age_reg == CFG_SETTLE && link_cfg_reg == QC_1L2M) |->
      (link_a_out == $past(proc_a_out, LNK_LAT_1L2M));
  endproperty
  a_link_1l2m: assert property (p_link_1l2m)
    else $error("Link delay for one lane two converters is not 7");

  property p_link_dec2;
    @(posedge clk_sys_in) disable iff (reset_in)
    (cfg_age_reg == CFG_SETTLE && link_cfg_reg == QC_4L2M_F1 && decim_reg[2:0] == DEC_BY_2)
      |-> (link_b_out == $past(proc_b_out, LNK_LAT_4L2M_DEC));
  endproperty
  a_link_dec2: assert property (p_link_dec2)
    else $error("Link delay with decimation by 2 is not 30");

  property p_lanes_replaced;
    @(posedge clk_sys_in) disable iff (reset_in)
    (cfg_age_reg == CFG_SETTLE && test_active && !ddc_mode) |->
      (proc_a_out == $past(pattern_word, LAT_FULL_BW - LAT_CONV) &&
       proc_b_out == $past(pattern_word, LAT_FULL_BW - LAT_CONV));
  endproperty
  a_lanes_replaced: assert property (p_lanes_replaced)
    else $error("Converter words leak through while a pattern is on");

  property p_short_seed;
    @(posedge clk_sys_in) disable iff (reset_in)
    (pn_rst && test_mode == TP_PN_SHORT) |-> (pattern_word == PN_FIRST_SHORT);
  endproperty
  a_short_seed: assert property (p_short_seed)
    else $error("Short noise generator is not held at its seed");

  property p_long_start;
    @(posedge clk_sys_in) disable iff (reset_in)
    ($changed(test_mode) && test_mode == TP_PN_LONG && !pn_rst) |->
      (pattern_word == PN_FIRST_LONG);
  endproperty
  a_long_start: assert property (p_long_start)
    else $error("Long noise does not start at its first word");

  property p_checker_alt;
    @(posedge clk_sys_in) disable iff (reset_in)
    (test_mode == TP_CHECK && sample_strobe) ##1 (test_mode == TP_CHECK && sample_strobe) |->
      (pattern_word == (($past(pattern_word) == PAT_CHK_A) ? PAT_CHK_B : PAT_CHK_A));
  endproperty
  a_checker_alt: assert property (p_checker_alt)
    else $error("Checkerboard does not alternate");

  property p_ramp_step;
    @(posedge clk_sys_in) disable iff (reset_in)
    (test_mode == TP_RAMP && sample_strobe) ##1 (test_mode == TP_RAMP) |->
      (pattern_word == SMP_W'($past(pattern_word) + RAMP_STEP));
  endproperty
  a_ramp_step: assert property (p_ramp_step)
    else $error("Ramp does not step by one");

  property p_user_wrap;
    @(posedge clk_sys_in) disable iff (reset_in)
    (test_mode == TP_USER && $stable(test_mode) && !test_sel_reg[BIT_USER_SINGLE] &&
     sample_strobe && user_idx_reg == USER_LAST_IDX) |=> (user_idx_reg == 2'h0 && !user_done_reg);
  endproperty
  a_user_wrap: assert property (p_user_wrap)
    else $error("Repeat mode does not return to the first word");

  property p_user_zero;
    @(posedge clk_sys_in) disable iff (reset_in)
    (test_mode == TP_USER && $stable(test_mode) && user_done_reg) |-> (pattern_word == PAT_ZERO);
  endproperty
  a_user_zero: assert property (p_user_zero)
    else $error("Single mode does not end in zero words");

endmodule

// file: atpl_src.sv
// Sample source model standing in for the converter front end
`timescale 1ns/1ps
module atpl_src (
  // Clock
  input wire logic clk_sys_in,
  // Converted samples
  output logic [13:0] smp_a_out,
  output logic [13:0] smp_b_out
);
  logic [13:0] cnt_reg = 14'h0000;
  // Free running count so each delayed word can be traced
  always @(posedge clk_sys_in)
  begin
    cnt_reg <= cnt_reg + 14'h0001;
  end
  // Lane B carries the inverse
  assign smp_a_out = cnt_reg;
  assign smp_b_out = ~cnt_reg;
endmodule

// file: tb_top.sv
// Register and pattern tests for the test pattern and latency block
`timescale 1ns/1ps
module tb_top;
  import atpl_pkg::*;
  logic clk_sys_in = 0, reset_in = 1, reg_write_in = 0, reg_read_in = 0;
  logic [ADDR_W-1:0] reg_addr_in = '0;
  logic [DATA_W-1:0] reg_wdata_in = '0, reg_rdata_out, rd;
  logic [SMP_W-1:0] sample_a_in, sample_b_in, conv_a_out, conv_b_out, v;
  logic [SMP_W-1:0] proc_a_out, proc_b_out, link_a_out, link_b_out;
  logic proc_valid_out, link_valid_out;
  logic [7:0] qc[10] = '{8'h01, 8'h40, 8'h41, 8'h80, 8'h81, 8'h0A, 8'h49, 8'h88, 8'h89, 8'h5B};
  int lk[10] = '{13, 28, 28, 53, 53, 7, 13, 28, 28, 4};
  logic [15:0] up[4] = '{16'h1234, 16'hABCD, 16'h5678, 16'hF00C};
  logic [13:0] cx[3] = '{PAT_MID, PAT_POS, PAT_NEG};
  int err_total = 0, checks_done = 0, nv = 0;
  // Clock
  initial forever #5 clk_sys_in = ~clk_sys_in;
  atpl_src SRC (.clk_sys_in(clk_sys_in), .smp_a_out(sample_a_in), .smp_b_out(sample_b_in));
  atpl_top DUT (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .sample_a_in(sample_a_in), .sample_b_in(sample_b_in),
    .conv_a_out(conv_a_out), .conv_b_out(conv_b_out), .proc_valid_out(proc_valid_out),
    .proc_a_out(proc_a_out), .proc_b_out(proc_b_out), .link_valid_out(link_valid_out),
    .link_a_out(link_a_out), .link_b_out(link_b_out));
  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One cycle register write
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_write_in <= 1'b0;
  endtask
  // Read, data taken in the cycle after the strobe
  task automatic rdv(input logic [11:0] a);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_read_in <= 1'b0;
    #1 rd = reg_rdata_out;
  endtask
  task automatic step;
    @(posedge clk_sys_in);
    #1;
  endtask
  // Let the delay ring flush after a setting change
  task automatic settle;
    repeat (256) step;
  endtask
  // Counts proc and link valid marks over 16 cycles
  task automatic vcount;
    nv = 0;
    repeat (16)
    begin
      step;
      nv += proc_valid_out + link_valid_out;
    end
  endtask
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #200_000;
    err_total++;
    test_done;
  end
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    wr(OFS_TEST_SEL, 8'h08);
    rdv(OFS_TEST_SEL);
    chk(rd, 16'h0008);
    rdv(12'h123);
    chk(rd, 16'h0000);
    for (int i = 0; i < 10; i++)
    begin
      wr(OFS_LINK_CFG, qc[i]);
      rdv(OFS_LATENCY);
      chk(rd, 16'(LAT_FULL_BW + lk[i]));
    end
    wr(OFS_TEST_SEL, 8'h00);
    wr(OFS_LINK_CFG, QC_1L2M);
    settle;
    chk(proc_a_out, 14'(sample_a_in - 14'(LAT_FULL_BW)));
    chk(link_a_out, 14'(sample_a_in - 14'(LAT_FULL_BW + LNK_LAT_1L2M)));
    wr(OFS_LINK_CFG, QC_4L2M_F1);
    wr(OFS_DECIM, 8'(DEC_BY_2));
    rdv(OFS_LATENCY);
    chk(rd, 16'(LAT_FULL_BW + 30));
    settle;
    chk(link_b_out, 14'(sample_b_in + 14'(LAT_FULL_BW + 30)));
    vcount;
    chk(16'(nv), 16'd16);
    wr(OFS_APP_MODE, 8'h01);
    for (int i = 1; i < 5; i++)
    begin
      wr(OFS_DECIM, 8'(i));
      wr(OFS_LINK_CFG, i[0] ? QC_4L4M : QC_4L8M);
      rdv(OFS_LATENCY);
      chk(rd, 16'(LAT_HB1_CPLX + (i[0] ? 13 : 7)));
    end
    $display("Latency test done");
    wr(OFS_DDC0_CTRL, 8'h01);
    wr(OFS_DDC1_CTRL, 8'h04);
    wr(OFS_TEST_SEL, 8'h02);
    settle;
    chk(proc_a_out, PAT_POS);
    chk(proc_b_out, PAT_POS);
    vcount;
    chk(16'(nv), 16'd2);
    wr(OFS_APP_MODE, 8'h00);
    wr(OFS_DECIM, 8'(DEC_BY_1));
    for (int i = 0; i < 3; i++)
    begin
      wr(OFS_TEST_SEL, 8'(i + 1));
      settle;
      chk(proc_a_out, cx[i]);
      chk(proc_b_out, cx[i]);
      chk(conv_a_out, 14'(sample_a_in - 14'h001A));
      chk(conv_b_out, 14'(sample_b_in + 14'h001A));
      chk(link_a_out, cx[i]);
    end
    for (int m = 0; m < 3; m++)
    begin
      wr(OFS_TEST_SEL, m == 0 ? 8'h04 : m == 1 ? 8'h07 : 8'h0F);
      settle;
      v = proc_a_out;
      step;
      if (m == 0)
        chk(proc_a_out, v === PAT_CHK_A ? PAT_CHK_B : PAT_CHK_A);
      else if (m == 1)
        chk(proc_a_out, v === PAT_ZERO ? PAT_ONES : PAT_ZERO);
      else
        chk(proc_a_out, 14'(v + RAMP_STEP));
    end
    wr(OFS_TEST_SEL, 8'h05);
    wr(OFS_TEST_SEL, 8'h25);
    settle;
    chk(proc_a_out, PN_FIRST_LONG);
    wr(OFS_TEST_SEL, 8'h05);
    repeat (3) step;
    chk(proc_a_out, 16'h0002);
    wr(OFS_TEST_SEL, 8'h16);
    settle;
    chk(proc_a_out, PN_FIRST_SHORT);
    $display("Pattern test done");
    for (int i = 0; i < 8; i++)
      wr(OFS_USER_FIRST + 12'(i), i[0] ? up[i / 2][7:0] : up[i / 2][15:8]);
    for (int s = 0; s < 2; s++)
    begin
      wr(OFS_TEST_SEL, 8'h01);
      wr(OFS_TEST_SEL, s == 0 ? 8'h08 : 8'h88);
      step;
      for (int k = 0; k < 8 && proc_a_out !== up[0][15:2]; k++)
        step;
      chk(proc_a_out, up[0][15:2]);
      for (int n = 1; n < 6; n++)
      begin
        step;
        chk(proc_a_out, (s == 1 && n > 3) ? PAT_ZERO : up[n % 4][15:2]);
      end
    end
    $display("User pattern test done");
    test_done;
  end
endmodule
